/* hdl/recorder_pkg.sv */
// Purpose: shared constants and types for the recorder command sequencer
// Assumes: 100 MHz core clock, nibble-wide host bus
// Notes:   delays count scaled microseconds, nominal at 8 kHz sampling
package recorder_pkg;

	// ----------------------------------------------------------------
	// clock and sampling rates
	// ----------------------------------------------------------------
	localparam int CLK_PERIOD_NS = 10;
	localparam int US_NS         = 1000;
	localparam int US_CYC        = US_NS / CLK_PERIOD_NS;
	// rates in tenths of kHz; nominal rate gives the unscaled timings
	localparam int NOM_RATE = 80;
	localparam int RATE_0   = 80;
	localparam int RATE_1   = 64;
	localparam int RATE_2   = 53;
	localparam int RATE_3   = 40;

	// ----------------------------------------------------------------
	// timings in scaled microseconds
	// ----------------------------------------------------------------
	localparam logic [9:0] T_CMD_US       = 10'h010; // 16
	localparam logic [9:0] T_LONG_US      = 10'h10E; // 270
	localparam logic [9:0] T_DATA_US      = 10'h032; // 50
	localparam logic [9:0] T_RESET_US     = 10'h07D; // 125
	localparam logic [9:0] T_ADDR_US      = 10'h3E8; // 1000
	localparam logic [9:0] T_EXT_START_US = 10'h0C8; // 200
	localparam logic [9:0] T_EXT_HI_US    = 10'h01F; // 31
	localparam logic [9:0] T_EXT_LO_US    = 10'h05E; // 94
	localparam logic [9:0] T_EXT_END_US   = 10'h0C8; // 200

	// ----------------------------------------------------------------
	// command codes, counts, status layout, reset values
	// ----------------------------------------------------------------
	localparam logic [3:0] CMD_NOP   = 4'h0;
	localparam logic [3:0] CMD_PAUSE = 4'h1;
	localparam logic [3:0] CMD_PLAY  = 4'h2;
	localparam logic [3:0] CMD_REC   = 4'h3;
	localparam logic [3:0] CMD_START = 4'h4;
	localparam logic [3:0] CMD_STOP  = 4'h5;
	localparam logic [3:0] CMD_SAMP  = 4'h6;
	localparam logic [3:0] CMD_CHANNEL_SELECT_CMD  = 4'h7;
	localparam logic [3:0] CMD_VDS   = 4'h8;
	localparam logic [3:0] CMD_ADDRESS_WRITE_CMD = 4'h9;
	localparam logic [3:0] CMD_ADDRESS_READ_CMD = 4'hA;
	localparam logic [3:0] CMD_DIRECT_TRANSFER_CMD  = 4'hB;
	localparam logic [3:0] CMD_EXT   = 4'hC;
	localparam logic [2:0] ADDR_LAST  = 3'h7;
	localparam logic [2:0] XADDR_LAST = 3'h2;
	localparam int ST_BUSY_BIT = 0;
	localparam int ST_RP_BIT   = 1;
	localparam int ST_VP_BIT   = 2;

	typedef enum logic [3:0] {
		ST_IDLE, ST_ADR_WR, ST_ADR_RD, ST_DT_ADDR, ST_DT_RUN,
		ST_ADDR_START, ST_RUN, ST_VSTBY, ST_PAUSED, ST_ADDR_END,
		ST_EXT_WAIT, ST_EXT_HI, ST_EXT_LO, ST_EXT_END
	} seq_e;

	typedef struct packed {
		logic       ce_n;
		logic       rd_n;
		logic       wr_n;
		logic [3:0] data;
	} host_pins_s;

	typedef struct packed {
		logic [1:0]  ce_s;
		logic [2:0]  rd_s;
		logic [2:0]  wr_s;
		logic [7:0]  din_s;
		logic [3:0]  strap_s;
		seq_e        st;
		logic        mode_play;
		logic        dt_data;
		logic        pend;
		logic [3:0]  pend_cmd;
		logic [1:0]  rate;
		logic [1:0]  channel_select_cmd;
		logic [1:0]  vd;
		logic [2:0]  nib;
		logic [31:0] addr;
		logic [7:0]  pre;
		logic [9:0]  tmr;
		logic [9:0]  busy_t;
		logic        rp;
		logic        vp;
		logic        act;
		logic [3:0]  dout;
		logic        doe;
		logic [3:0]  word;
		logic        stb;
	} ctl_s;

	localparam ctl_s CTL_RST = '{
		ce_s: 2'h3, rd_s: 3'h7, wr_s: 3'h7, st: ST_IDLE,
		busy_t: T_RESET_US, default: '0
	};

endpackage

/* hdl/recorder_command_sequencer.sv */
// Purpose: command interpreter and sequencer of the voice recorder core
// Assumes: host pins are asynchronous; straps are slow levels
// Notes:   all delays tick on a prescaler that follows the sample rate
// Functional notes
// RQ1: start raises, stop drops the activity indicator within 1 ms.
// RQ2: start sets the record/play flag within 16 us.
// RQ3: start with voice trigger enabled sets voice/pause flag within 16 us.
// RQ4: stop during voice standby releases standby within 500 us.
// RQ5: pause during record or play sets voice/pause flag within 16 us.
// RQ6: start or stop while paused clears voice/pause flag within 500 us.
// RQ7: host waits 16 us after transfer command, low, middle nibbles; 270 upper.
// RQ8: host waits 16 us after record and stop in direct transfer.
// RQ9: host waits 50 us after data word and play in direct transfer.
// RQ10: external-data command raises activity between 125 and 330 us.
// RQ11: external mode pulses activity each sample, 31 us high, 94 low.
// RQ12: host completes its data strobe within 120 us of each rise.
// RQ13: host waits 16 us from last data write to stop.
// RQ14: external stop raises activity within 100 us, ends within 250 us.
// RQ15: about 1 ms of address handling at start and at record end.
// RQ16: all command delays scale with the sampling period.
// RQ17: looping playback only with exactly one serial memory attached.
// RQ18: simple commands take one nibble; rate, channel, voice detect take two.
// RQ19: address write: host checks busy, then sends nibbles two to nine.
// RQ20: address read: busy cannot be polled; host times each read.
// RQ21: address read: 270 us before first read, 50 us between reads.
// RQ22: busy, record/play and voice/pause flags are read as a status nibble.
`timescale 1ns/1ps
module recorder_command_sequencer
	import recorder_pkg::*;
#(
	parameter int US_CYCLES = recorder_pkg::US_CYC
)
(
	// clock, reset, enable
	input  wire logic                    core_clk_in,
	input  wire logic                    reset_n_in,
	input  wire logic                    clk_en_in,
	// host nibble bus
	input  wire recorder_pkg::host_pins_s host_in,
	output logic [3:0]                   data_out,
	output logic                         data_oe_out,
	// straps and datapath side
	input  wire logic                    single_mem_in,
	input  wire logic                    repeat_in,
	input  wire logic                    voice_detected_in,
	input  wire logic                    mem_end_in,
	input  wire logic [3:0]              mem_rdata_in,
	input  wire logic [3:0]              adpcm_in,
	// sequencer outputs
	output logic                         activity_indicator_out,
	output logic [3:0]                   word_out,
	output logic                         word_stb_out,
	output logic [31:0]                  addr_out,
	output logic [1:0]                   rate_out,
	output logic [1:0]                   channel_out,
	output logic [1:0]                   vd_level_out,
	output logic                         play_mode_out
);
	import recorder_pkg::*;

	ctl_s       q;
	ctl_s       n;
	logic       tick;
	logic       wr_ev;
	logic       rd_fall;
	logic       rd_rise;
	logic       ext_st;
	logic       data_wr;
	logic       cmd_ev;
	logic       loop_ok;
	logic [3:0] wdat;

	// ----------------------------------------------------------------
	// scaled microsecond prescaler reload
	// ----------------------------------------------------------------
	function automatic logic [7:0] rate_reload(input logic [1:0] r);
		int d;
		case (r)
			2'h1:    d = RATE_1;
			2'h2:    d = RATE_2;
			2'h3:    d = RATE_3;
			default: d = RATE_0;
		endcase
		return 8'(US_CYCLES * NOM_RATE / d);
	endfunction

	// ----------------------------------------------------------------
	// bus events
	// ----------------------------------------------------------------
	assign tick    = (q.pre == 8'h00);
	assign wdat    = q.din_s[7:4];
	assign wr_ev   = q.wr_s[1] & ~q.wr_s[2] & ~q.ce_s[1];
	assign rd_fall = ~q.rd_s[1] & q.rd_s[2] & ~q.ce_s[1];
	assign rd_rise = q.rd_s[1] & ~q.rd_s[2];
	assign loop_ok = q.strap_s[3] & q.strap_s[2];
	assign ext_st  = (q.st == ST_EXT_WAIT) || (q.st == ST_EXT_HI)
		|| (q.st == ST_EXT_LO);
	assign data_wr = wr_ev && (wdat != CMD_STOP) && !q.pend
		&& (((q.st == ST_DT_RUN) && q.dt_data) || (ext_st && q.mode_play));
	assign cmd_ev  = wr_ev && !q.pend && !data_wr
		&& (q.st != ST_ADR_WR) && (q.st != ST_DT_ADDR);

	// ----------------------------------------------------------------
	// next state
	// ----------------------------------------------------------------
	always_comb
	begin
		logic fin;
		fin = 1'b0;
		n = q;
		n.stb = 1'b0;
		n.ce_s = {q.ce_s[0], host_in.ce_n};
		n.rd_s = {q.rd_s[1:0], host_in.rd_n};
		n.wr_s = {q.wr_s[1:0], host_in.wr_n};
		n.din_s = {q.din_s[3:0], host_in.data};
		n.strap_s = {q.strap_s[1:0], single_mem_in, repeat_in};
		n.pre = tick ? rate_reload(q.rate) - 8'h01 : q.pre - 8'h01; // RQ16
		if (tick && q.tmr != 10'h000)
			n.tmr = q.tmr - 10'h001;
		if (tick && q.busy_t != 10'h000)
			n.busy_t = q.busy_t - 10'h001;

		// host reads: status unless a data path owns the bus
		if (rd_fall)
		begin
			n.doe = 1'b1;
			n.dout = 4'h0;
			n.dout[ST_BUSY_BIT] = (q.busy_t != 10'h000); // RQ22
			n.dout[ST_RP_BIT] = q.rp;
			n.dout[ST_VP_BIT] = q.vp;
			if (q.st == ST_ADR_RD)
				n.dout = q.addr[{q.nib, 2'b00} +: 4]; // RQ20
			else if (q.st == ST_DT_RUN && q.mode_play)
				n.dout = mem_rdata_in;
			else if (ext_st && !q.mode_play)
				n.dout = adpcm_in; // RQ12
		end
		if (rd_rise)
		begin
			n.doe = 1'b0;
			if (q.st == ST_ADR_RD)
			begin
				n.nib = q.nib + 3'h1;
				if (q.nib == ADDR_LAST)
					n.st = ST_IDLE;
			end
		end

		// timed sequencing
		case (q.st)
			ST_ADDR_START:
				if (q.tmr == 10'h000)
				begin
					n.act = 1'b1; // RQ1
					n.st = ST_RUN;
				end
			ST_VSTBY:
				if (voice_detected_in)
				begin
					n.vp = 1'b0;
					n.rp = 1'b1;
					n.st = ST_ADDR_START;
					n.tmr = T_ADDR_US;
				end
			ST_RUN:
				if (mem_end_in)
				begin
					if (q.mode_play && loop_ok)
					begin
						n.st = ST_ADDR_START; // RQ17
						n.tmr = T_ADDR_US;
					end
					else
						fin = 1'b1;
				end
			ST_ADDR_END:
				if (q.tmr == 10'h000)
				begin
					n.rp = 1'b0;
					n.st = ST_IDLE;
				end
			ST_EXT_WAIT:
				if (q.tmr == 10'h000)
				begin
					n.act = 1'b1; // RQ10
					n.st = ST_EXT_HI;
					n.tmr = T_EXT_HI_US;
				end
			ST_EXT_HI:
				if (q.tmr == 10'h000)
				begin
					n.act = 1'b0; // RQ11
					n.st = ST_EXT_LO;
					n.tmr = T_EXT_LO_US;
				end
			ST_EXT_LO:
				if (q.tmr == 10'h000)
				begin
					n.act = 1'b1; // RQ11
					n.st = ST_EXT_HI;
					n.tmr = T_EXT_HI_US;
				end
			ST_EXT_END:
				if (q.tmr == 10'h000)
				begin
					n.act = 1'b0;
					n.rp = 1'b0;
					n.st = ST_IDLE;
				end
			default:
				n.st = n.st;
		endcase

		// second nibble of a two-nibble command
		if (wr_ev && q.pend)
		begin
			n.pend = 1'b0; // RQ18
			n.busy_t = T_CMD_US;
			case (q.pend_cmd)
				CMD_SAMP: n.rate = wdat[1:0];
				CMD_CHANNEL_SELECT_CMD: n.channel_select_cmd = wdat[1:0];
				default:  n.vd = wdat[1:0];
			endcase
		end

		// address nibbles of address write and direct transfer
		if (wr_ev && !q.pend && q.st == ST_ADR_WR)
		begin
			n.addr[{q.nib, 2'b00} +: 4] = wdat; // RQ19
			n.busy_t = T_DATA_US;
			n.nib = q.nib + 3'h1;
			if (q.nib == ADDR_LAST)
				n.st = ST_IDLE;
		end
		if (wr_ev && !q.pend && q.st == ST_DT_ADDR)
		begin
			n.addr[{q.nib, 2'b00} +: 4] = wdat;
			n.nib = q.nib + 3'h1;
			n.busy_t = T_CMD_US; // RQ7
			if (q.nib == XADDR_LAST)
			begin
				n.busy_t = T_LONG_US; // RQ7
				n.st = ST_DT_RUN;
			end
		end

		// data words of direct transfer and external playback
		if (data_wr)
		begin
			n.word = wdat;
			n.stb = 1'b1;
			n.busy_t = ext_st ? T_CMD_US : T_DATA_US; // RQ9 RQ13
		end

		// single-nibble and leading command nibbles
		if (cmd_ev)
		begin
			n.busy_t = T_CMD_US; // RQ8
			case (wdat)
				CMD_REC:
				begin
					n.mode_play = 1'b0;
					n.dt_data = (q.st == ST_DT_RUN);
				end
				CMD_PLAY:
				begin
					n.mode_play = 1'b1;
					if (q.st == ST_DT_RUN)
						n.busy_t = T_DATA_US; // RQ9
				end
				CMD_START:
					if (q.st == ST_IDLE && q.vd != 2'h0)
					begin
						n.vp = 1'b1; // RQ3
						n.st = ST_VSTBY;
					end
					else if (q.st == ST_IDLE)
					begin
						n.rp = 1'b1; // RQ2
						n.st = ST_ADDR_START;
						n.tmr = T_ADDR_US; // RQ15
					end
					else if (q.st == ST_PAUSED)
					begin
						n.vp = 1'b0; // RQ6
						n.st = ST_RUN;
					end
				CMD_STOP:
					if (q.st == ST_VSTBY)
					begin
						n.vp = 1'b0; // RQ4
						n.rp = 1'b0;
						n.st = ST_IDLE;
					end
					else if (ext_st)
					begin
						n.act = 1'b1; // RQ14
						n.st = ST_EXT_END;
						n.tmr = T_EXT_END_US; // RQ14
					end
					else if (q.st == ST_DT_RUN)
					begin
						n.dt_data = 1'b0;
						n.st = ST_IDLE;
					end
					else if (q.st == ST_RUN || q.st == ST_PAUSED
						|| q.st == ST_ADDR_START)
						fin = 1'b1; // RQ6
				CMD_PAUSE:
					if (q.st == ST_RUN)
					begin
						n.vp = 1'b1; // RQ5
						n.st = ST_PAUSED;
					end
				CMD_SAMP, CMD_CHANNEL_SELECT_CMD, CMD_VDS:
				begin
					n.pend = 1'b1; // RQ18
					n.pend_cmd = wdat;
				end
				CMD_ADDRESS_WRITE_CMD, CMD_ADDRESS_READ_CMD:
					if (q.st == ST_IDLE)
					begin
						n.busy_t = T_LONG_US; // RQ21
						n.nib = 3'h0;
						n.st = (wdat == CMD_ADDRESS_WRITE_CMD) ? ST_ADR_WR : ST_ADR_RD;
					end
				CMD_DIRECT_TRANSFER_CMD:
					if (q.st == ST_IDLE)
					begin
						n.nib = 3'h0;
						n.dt_data = 1'b0;
						n.st = ST_DT_ADDR;
					end
				CMD_EXT:
					if (q.st == ST_IDLE)
					begin
						n.rp = 1'b1;
						n.st = ST_EXT_WAIT;
						n.tmr = T_EXT_START_US; // RQ10
					end
				default:
					n.busy_t = T_CMD_US;
			endcase
		end

		// end of a record or playback run
		if (fin)
		begin
			n.act = 1'b0; // RQ1
			n.vp = 1'b0;
			if (!q.mode_play)
			begin
				n.st = ST_ADDR_END;
				n.tmr = T_ADDR_US; // RQ15
			end
			else
			begin
				n.rp = 1'b0;
				n.st = ST_IDLE;
			end
		end
	end

	always_ff @(posedge core_clk_in or negedge reset_n_in)
	begin
		if (!reset_n_in)
			q <= CTL_RST;
		else if (clk_en_in)
			q <= n;
	end

	// ----------------------------------------------------------------
	// outputs
	// ----------------------------------------------------------------
	assign data_out               = q.dout;
	assign data_oe_out            = q.doe;
	assign activity_indicator_out = q.act;
	assign word_out               = q.word;
	assign word_stb_out           = q.stb;
	assign addr_out               = q.addr;
	assign rate_out               = q.rate;
	assign channel_out            = q.channel_select_cmd;
	assign vd_level_out           = q.vd;
	assign play_mode_out          = q.mode_play;

	// ----------------------------------------------------------------
	// checks
	// ----------------------------------------------------------------
	default clocking @(posedge core_clk_in); endclocking
	default disable iff (!reset_n_in);

	rp_on_start_a: assert property (clk_en_in && cmd_ev // RQ2
		&& wdat == CMD_START && q.st == ST_IDLE && q.vd == 2'h0
		|=> q.rp && q.st == ST_ADDR_START && q.tmr == T_ADDR_US)
		else $error("start did not set record flag");
	vp_on_trigger_a: assert property (clk_en_in && cmd_ev // RQ3
		&& wdat == CMD_START && q.st == ST_IDLE && q.vd != 2'h0
		|=> q.vp && !q.rp && q.st == ST_VSTBY)
		else $error("voice standby not entered");
	standby_release_a: assert property (clk_en_in && cmd_ev // RQ4
		&& wdat == CMD_STOP && q.st == ST_VSTBY
		|=> !q.vp && q.st == ST_IDLE)
		else $error("stop did not release standby");
	vp_on_pause_a: assert property (clk_en_in && cmd_ev // RQ5
		&& wdat == CMD_PAUSE && q.st == ST_RUN |=> q.vp)
		else $error("pause did not set flag");
	vp_clear_a: assert property (clk_en_in && cmd_ev // RQ6
		&& (wdat == CMD_START || wdat == CMD_STOP)
		&& q.st == ST_PAUSED |=> !q.vp)
		else $error("pause flag not cleared");
	act_drop_a: assert property (clk_en_in && cmd_ev // RQ1
		&& wdat == CMD_STOP && q.st == ST_RUN |=> !q.act)
		else $error("activity not dropped on stop");
	ext_pulse_a: assert property (clk_en_in && q.st == ST_EXT_LO // RQ11
		&& q.tmr == 10'h000 && !cmd_ev
		|=> q.act && q.tmr == T_EXT_HI_US)
		else $error("sample pulse not started");
	ext_stop_a: assert property (clk_en_in && cmd_ev // RQ14
		&& wdat == CMD_STOP && ext_st
		|=> q.act && q.st == ST_EXT_END && q.tmr == T_EXT_END_US)
		else $error("external stop wrong");
	ext_start_a: assert property (clk_en_in && cmd_ev // RQ10
		&& wdat == CMD_EXT && q.st == ST_IDLE
		|=> !q.act && q.tmr == T_EXT_START_US ##1 !q.act)
		else $error("external start wrong");
	loop_gate_a: assert property (clk_en_in && q.st == ST_RUN // RQ17
		&& mem_end_in && !loop_ok && !cmd_ev |=> q.st != ST_ADDR_START)
		else $error("loop without single memory");
	two_nibble_a: assert property (clk_en_in && cmd_ev // RQ18
		&& wdat == CMD_SAMP |=> q.pend ##0 (!wr_ev) [*1])
		else $error("second nibble not awaited");

endmodule

/* dv/recorder_host_model.sv */
// Purpose: host microcontroller model driving the nibble bus
// Assumes: tick holds core cycles per scaled microsecond
// Notes:   every wait after an access is one tick over the minimum
`timescale 1ns/1ps
module recorder_host_model
(
	// clock
	input  wire logic                core_clk_in,
	// nibble bus
	output recorder_pkg::host_pins_s pins_out,
	input  wire logic [3:0]          data_in,
	input  wire logic                data_oe_in
);
	import recorder_pkg::*;

	int tick = 2;

	initial pins_out = '{ce_n: 1'b1, rd_n: 1'b1, wr_n: 1'b1, data: 4'h0};

	// ----------------------------------------------------------------
	// bus cycles
	// ----------------------------------------------------------------
	task automatic idle(input int us);
		repeat ((us + 1) * tick) @(posedge core_clk_in);
	endtask

	// one nibble per strobe; data held past the rising strobe edge
	task automatic wr(input logic [3:0] n, input int us);
		@(posedge core_clk_in);
		pins_out.ce_n <= 1'b0;
		pins_out.data <= n;
		repeat (2) @(posedge core_clk_in);
		pins_out.wr_n <= 1'b0;
		repeat (5) @(posedge core_clk_in);
		pins_out.wr_n <= 1'b1;
		repeat (2) @(posedge core_clk_in);
		pins_out.ce_n <= 1'b1;
		pins_out.data <= ~n;
		idle(us);
	endtask

	// an address or data read cannot show busy, so fixed waits pace it
	task automatic rd(output logic [3:0] n, input int us);
		@(posedge core_clk_in);
		pins_out.ce_n <= 1'b0;
		pins_out.rd_n <= 1'b0;
		repeat (6) @(posedge core_clk_in);
		n = data_oe_in ? data_in : 4'hx;
		pins_out.rd_n <= 1'b1;
		repeat (2) @(posedge core_clk_in);
		pins_out.ce_n <= 1'b1;
		idle(us);
	endtask
endmodule

/* dv/recorder_command_sequencer_tb.sv */
// Purpose: self-checking bench of the recorder command sequencer
// Assumes: host model keeps the bus waits; one tick is t core cycles
// Notes:   activity timing is measured on the falling clock edge
`timescale 1ns/1ps
module recorder_command_sequencer_tb;
	import recorder_pkg::*;

	localparam int USC = 2;

	logic        core_clk_in = 1'b0;
	logic        reset_n_in = 1'b0;
	logic        single_mem_in = 1'b0;
	logic        repeat_in = 1'b0;
	logic        voice_detected_in = 1'b0;
	logic        mem_end_in = 1'b0;
	logic [3:0]  mem_rdata_in = 4'h0;
	logic [3:0]  adpcm_in = 4'h0;
	host_pins_s  host_pins;
	logic [3:0]  data_out;
	logic        data_oe_out;
	logic        activity_indicator_out;
	logic [3:0]  word_out;
	logic [31:0] addr_out;
	logic [1:0]  rate_out;
	logic [1:0]  channel_out;
	logic [1:0]  vd_level_out;
	logic        clk_en_in = 1'b1;
	logic        word_stb_out;
	logic        play_mode_out;
	int          n_stb = 0;
	int          n_fail = 0;
	int          samples_checked = 0;
	int          seed = 32'h8fbf;
	int          t = USC;
	int          n;
	logic [3:0]  s;
	logic [31:0] a;
	logic        act_q = 1'b0;
	int          run = 0;
	int          hi_w = 0;
	int          lo_w = 0;

	always #5 core_clk_in = ~core_clk_in;

	recorder_command_sequencer #(.US_CYCLES(USC)) uut
	(
		.core_clk_in, .reset_n_in, .clk_en_in, .host_in(host_pins),
		.data_out, .data_oe_out, .single_mem_in, .repeat_in,
		.voice_detected_in, .mem_end_in, .mem_rdata_in, .adpcm_in,
		.activity_indicator_out, .word_out, .word_stb_out, .addr_out,
		.rate_out, .channel_out, .vd_level_out, .play_mode_out
	);

	recorder_host_model host
	(
		.core_clk_in, .pins_out(host_pins), .data_in(data_out),
		.data_oe_in(data_oe_out)
	);

	// ----------------------------------------------------------------
	// checks and helpers
	// ----------------------------------------------------------------
	// widths of the last completed high and low activity pulses
	always @(negedge core_clk_in)
	begin
		act_q <= activity_indicator_out;
		if (activity_indicator_out !== act_q)
		begin
			if (act_q)
				hi_w <= run;
			else
				lo_w <= run;
			run <= 1;
		end
		else
			run <= run + 1;
	end

	// data word strobes seen so far
	always @(negedge core_clk_in)
		if (word_stb_out === 1'b1)
			n_stb <= n_stb + 1;

	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		samples_checked++;
		if (got !== exp)
		begin
			n_fail++;
			$display("Error at %0t: got %h expected %h", $time, got, exp);
		end
	endtask

	task automatic chk_win(input int got, input int lo, input int hi);
		samples_checked++;
		if (got < lo || got > hi)
		begin
			n_fail++;
			$display("Error at %0t: got %h expected %h..%h", $time, got, lo, hi);
		end
	endtask

	task automatic wait_act(input logic lvl, output int cnt);
		cnt = 0;
		while (activity_indicator_out !== lvl && cnt < 4000 * t)
		begin
			@(negedge core_clk_in);
			cnt++;
		end
	endtask

	task automatic status(output logic [3:0] v);
		host.rd(v, 0);
	endtask

	function automatic int per(input int r);
		int k[4] = '{RATE_0, RATE_1, RATE_2, RATE_3};
		return USC * NOM_RATE / k[r];
	endfunction

	// data nibbles may not carry the stop code
	function automatic logic [31:0] no_stop(input logic [31:0] v);
		for (int k = 0; k < 8; k++)
			if (v[4 * k +: 4] == CMD_STOP)
				v[4 * k +: 4] = 4'h4;
		return v;
	endfunction

	task automatic results;
		$display("checked %0d, failed %0d", samples_checked, n_fail);
		if (n_fail == 0 && samples_checked > 0)
			$display("Testbench passed");
		else
			$display("Testbench failed");
		$finish;
	endtask

	initial
	begin
		repeat (90000) @(posedge core_clk_in);
		n_fail++;
		results();
	end

	// ----------------------------------------------------------------
	// scenarios
	// ----------------------------------------------------------------
	initial
	begin
		mem_rdata_in <= 4'($random(seed));
		repeat (16) @(posedge core_clk_in);
		reset_n_in <= 1'b1;
		status(s);
		chk(32'(s[0]), 32'h1);
		host.idle(125);
		status(s);
		chk(32'(s[0]), 32'h0);
		for (int r = 3; r >= 0; r--)
		begin
			host.wr(CMD_SAMP, 16);
			t = per(r);
			host.tick = t;
			host.wr(4'(r), 16);
			chk(32'(rate_out), 32'(r));
			@(posedge core_clk_in);
			adpcm_in <= 4'($random(seed));
			host.wr(CMD_EXT, 0);
			wait_act(1'b1, n);
			chk_win(n, 124 * t - 8, 330 * t);
			repeat (3)
			begin
				host.rd(s, 0);
				chk(32'(s), 32'(adpcm_in));
				wait_act(1'b0, n);
				wait_act(1'b1, n);
			end
			host.rd(s, 0);
			chk_win(hi_w, 30 * t - 1, 32 * t + 1);
			chk_win(lo_w, 93 * t - 1, 95 * t + 1);
			wait_act(1'b0, n);
			host.wr(CMD_STOP, 0);
			wait_act(1'b1, n);
			chk_win(n, 0, 100 * t);
			host.idle(250);
			status(s);
			chk(32'(s[1]), 32'h0);
		end
		host.wr(CMD_START, 16);
		status(s);
		chk(32'(s[1]), 32'h1);
		wait_act(1'b1, n);
		chk_win(n, 970 * t, 1001 * t);
		host.wr(CMD_PAUSE, 16);
		status(s);
		chk(32'(s[2]), 32'h1);
		host.wr(CMD_START, 500);
		status(s);
		chk(32'(s[2:1]), 32'h1);
		host.wr(CMD_STOP, 0);
		wait_act(1'b0, n);
		chk_win(n, 0, 1000 * t);
		host.idle(400);
		status(s);
		chk(32'(s[1]), 32'h1);
		host.idle(600);
		status(s);
		chk(32'(s[1]), 32'h0);
		host.wr(CMD_VDS, 16);
		host.wr(4'h1, 16);
		chk(32'(vd_level_out), 32'h1);
		host.wr(CMD_START, 16);
		status(s);
		chk(32'(s[2]), 32'h1);
		host.wr(CMD_STOP, 500);
		status(s);
		chk(32'(s[2]), 32'h0);
		host.wr(CMD_START, 16);
		@(posedge core_clk_in);
		voice_detected_in <= 1'b1;
		@(posedge core_clk_in);
		voice_detected_in <= 1'b0;
		status(s);
		chk(32'(s[2:1]), 32'h1);
		wait_act(1'b1, n);
		chk_win(n, 970 * t, 1001 * t);
		host.wr(CMD_STOP, 16);
		host.idle(1000);
		status(s);
		chk(32'(s[1]), 32'h0);
		host.wr(CMD_VDS, 16);
		host.wr(4'h0, 16);
		a = $random(seed);
		host.wr(CMD_CHANNEL_SELECT_CMD, 16);
		host.wr({2'h0, a[1:0]}, 16);
		chk(32'(channel_out), 32'(a[1:0]));
		a = no_stop($random(seed));
		host.wr(CMD_ADDRESS_WRITE_CMD, 270);
		for (int k = 0; k < 8; k++)
			host.wr(a[4 * k +: 4], 50);
		chk(addr_out, a);
		host.wr(CMD_ADDRESS_READ_CMD, 270);
		for (int k = 0; k < 8; k++)
		begin
			host.rd(s, 50);
			chk(32'(s), 32'(a[4 * k +: 4]));
		end
		a = no_stop($random(seed));
		host.wr(CMD_DIRECT_TRANSFER_CMD, 16);
		for (int k = 0; k < 3; k++)
			host.wr(a[4 * k +: 4], (k == 2) ? 270 : 16);
		chk(32'(addr_out[11:0]), 32'(a[11:0]));
		host.wr(CMD_REC, 16);
		chk(32'(play_mode_out), 32'h0);
		host.wr(a[15:12], 50);
		chk(32'(word_out), 32'(a[15:12]));
		chk(32'(n_stb), 32'h1);
		host.wr(CMD_STOP, 16);
		host.wr(CMD_PLAY, 50);
		chk(32'(play_mode_out), 32'h1);
		for (int i = 0; i < 2; i++)
		begin
			@(posedge core_clk_in);
			single_mem_in <= i[0];
			repeat_in <= 1'b1;
			host.wr(CMD_START, 16);
			wait_act(1'b1, n);
			@(posedge core_clk_in);
			mem_end_in <= 1'b1;
			@(posedge core_clk_in);
			mem_end_in <= 1'b0;
			repeat (20) @(negedge core_clk_in);
			chk(32'(activity_indicator_out), 32'(i));
			host.idle(1000);
			host.wr(CMD_PAUSE, 16);
			host.wr(CMD_STOP, 500);
			status(s);
			chk(32'(s[2:1]), 32'h0);
		end
		// a start strobe made while frozen must leave no trace
		@(posedge core_clk_in);
		clk_en_in <= 1'b0;
		host.wr(CMD_START, 0);
		@(posedge core_clk_in);
		clk_en_in <= 1'b1;
		status(s);
		chk(32'(s[2:0]), 32'h0);
		chk(32'(activity_indicator_out), 32'h0);
		results();
	end
endmodule
